// >>> verilog/ldl_defs.svh
// Register map, field positions, reset values and timing counts
`ifndef LDL_DEFS_SVH
`define LDL_DEFS_SVH

`define LDL_DATA_W       32
`define LDL_ADDR_W       8

`define LDL_REG_CTRL     8'h00
`define LDL_REG_TXDATA   8'h04
`define LDL_REG_CTL_LO   8'h08
`define LDL_REG_CTL_HI   8'h0C
`define LDL_REG_STATUS   8'h10
`define LDL_REG_RXDATA   8'h14

`define LDL_CTRL_RUN     0
`define LDL_CTRL_VSEL    1
`define LDL_TX_VOICE_LSB 0
`define LDL_TX_SIG_LSB   8
`define LDL_CTLHI_PAY_W  4
`define LDL_CTLHI_WEN    8
`define LDL_ST_ID_LSB    0
`define LDL_ST_ID_VALID  8
`define LDL_ST_ONE_WIRE  9
`define LDL_ST_PRESENT   10
`define LDL_ST_CTL_BUSY  11
`define LDL_ST_FRM_LSB   16
`define LDL_RX_VOICE_LSB 0
`define LDL_RX_CTL_LSB   8
`define LDL_RX_SIG_LSB   16

`define LDL_RUN_RST      1'b0
`define LDL_IDLE_BYTE    8'hFF

`define LDL_REF_CLK_KHZ  20000
`define LDL_BIT_KBPS     512
`define LDL_FRAME_US     125
`define LDL_HALF_CYC     (`LDL_REF_CLK_KHZ / (2 * `LDL_BIT_KBPS))
`define LDL_FRAME_BITS   64
`define LDL_HALF_BITS    32
`define LDL_CTL_LAST     3'h5
`define LDL_ID_LAST      4'h7
`define LDL_STRAP_WAIT   2'h3

`endif

// >>> verilog/ldl_pkg.sv
// Shared types of the line datalink
package ldl_pkg;
  typedef logic [7:0]  ldl_byte_t;
  typedef logic [31:0] ldl_word_t;
  typedef enum logic {
    LDL_VOICE_PRI = 1'b0,
    LDL_VOICE_SEC = 1'b1
  } ldl_voice_e;
  typedef struct packed {
    ldl_byte_t voice_pri;
    ldl_byte_t voice_sec;
    ldl_byte_t control;
    ldl_byte_t signaling;
  } ldl_frame_s;
endpackage

// >>> verilog/ldl_link_if.sv
// Cable between voice module and line interface board
`timescale 1ns/1ns
interface ldl_link_if;
  logic bit_clk;
  logic link_direction;
  logic mod_out_data;
  logic mod_out_en;
  logic brd_out_data;
  logic brd_out_en;
  logic brd_in_data;
  logic brd_in_en;
  logic out_wire;
  logic identification_line;
  logic interface_board_reset_n;
  logic module_present_n;
  logic interface_present_n;
  logic wire_mode_n;

  // Undriven wires float high
  assign out_wire = mod_out_en ? mod_out_data :
                    (brd_out_en ? brd_out_data : 1'b1);
  assign identification_line = brd_in_en ? brd_in_data : 1'b1;

  modport module_mp (
    input  bit_clk,
    input  link_direction,
    input  out_wire,
    input  identification_line,
    input  interface_present_n,
    input  wire_mode_n,
    output mod_out_data,
    output mod_out_en,
    output interface_board_reset_n,
    output module_present_n
  );

  modport board_mp (
    output bit_clk,
    output link_direction,
    input  out_wire,
    output brd_out_data,
    output brd_out_en,
    output brd_in_data,
    output brd_in_en,
    input  interface_board_reset_n,
    input  module_present_n,
    output interface_present_n,
    output wire_mode_n
  );
endinterface

// >>> verilog/ldl_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module ldl_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

// >>> verilog/ldl_module_end.sv
// Voice module end of the line datalink: link slave with register port
`timescale 1ns/1ns
`include "ldl_defs.svh"
module ldl_module_end
  import ldl_pkg::*;
#(
  parameter int DW = `LDL_DATA_W
) (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  ldl_link_if.module_mp               link,
  input  wire logic [`LDL_ADDR_W-1:0] addr,
  input  wire logic [DW-1:0]          wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [DW-1:0]          rdata
);
  logic [5:0]  pin_s;
  logic        clk_s, dir_s, outw_s, inw_s, mode_n_s, pres_n_s;
  logic        clk_d_r, dir_d_r;
  logic        rise, fall, frame_start, settled;
  logic        run_r, one_wire_r;
  ldl_voice_e  vsel_r;
  ldl_byte_t   tx_voice_r, tx_sig_r, id_r;
  logic [35:0] ctl_pay_r;
  logic        ctl_wen_r, ctl_busy_r, ctl_sent_r;
  logic [2:0]  ctl_idx_r;
  logic [1:0]  strap_cnt_r;
  ldl_word_t   tx_sh_r, rx_sh_r, rx_word_r;
  logic [4:0]  rx_cnt_r;
  logic [3:0]  lo_cnt_r;
  ldl_byte_t   in_sh_r;
  logic        id_armed_r, id_valid_r;
  logic [7:0]  frames_r;
  logic        out_data_r;
  logic        bit_in;
  ldl_frame_s  tx_frame;
  logic [DW-1:0] status_w, rxdata_w;

  // Control byte: framing bit, active-low write enable, six payload bits
  function automatic ldl_byte_t ctl_byte_f(
    input logic        busy,
    input logic [2:0]  idx,
    input logic        wen,
    input logic [35:0] pay
  );
    logic [5:0] base;
    base = 6'd35 - 6'(6 * idx);
    if (busy)
      ctl_byte_f = {idx != 3'h0, ~wen, pay[base -: 6]};
    else
      ctl_byte_f = `LDL_IDLE_BYTE;
  endfunction

  ldl_sync #(.W(6)) ldl_sync_inst (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     ({link.bit_clk, link.link_direction, link.out_wire,
               link.identification_line, link.wire_mode_n,
               link.interface_present_n}),
    .dout    (pin_s)
  );
  assign {clk_s, dir_s, outw_s, inw_s, mode_n_s, pres_n_s} = pin_s;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      clk_d_r <= 1'b0;
      dir_d_r <= 1'b0;
    end else begin
      clk_d_r <= clk_s;
      dir_d_r <= dir_s;
    end
  end
  // Bit clock edges ignored until the synchroniser holds real pin levels; frame_start is not gated
  assign settled     = strap_cnt_r == `LDL_STRAP_WAIT;
  assign rise        = clk_s & ~clk_d_r & settled;
  assign fall        = ~clk_s & clk_d_r & settled;
  assign frame_start = dir_s & ~dir_d_r;

  // Board reset follows the run bit, cleared by our own reset
  assign link.interface_board_reset_n = run_r;
  assign link.module_present_n        = 1'b0;

  // Wire-count strap taken once the synchroniser has settled
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      strap_cnt_r <= 2'h0;
      one_wire_r  <= 1'b0;
    end else if (strap_cnt_r != `LDL_STRAP_WAIT) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == `LDL_STRAP_WAIT - 2'h1)
        one_wire_r <= ~mode_n_s;
    end
  end

  // Register writes
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      run_r      <= `LDL_RUN_RST;
      vsel_r     <= LDL_VOICE_PRI;
      tx_voice_r <= `LDL_IDLE_BYTE;
      tx_sig_r   <= `LDL_IDLE_BYTE;
      ctl_pay_r  <= '0;
      ctl_wen_r  <= 1'b0;
    end else if (wr) begin
      case (addr)
        `LDL_REG_CTRL: begin
          run_r  <= wdata[`LDL_CTRL_RUN];
          vsel_r <= ldl_voice_e'(wdata[`LDL_CTRL_VSEL]);
        end
        `LDL_REG_TXDATA: begin
          tx_voice_r <= wdata[`LDL_TX_VOICE_LSB +: 8];
          tx_sig_r   <= wdata[`LDL_TX_SIG_LSB +: 8];
        end
        `LDL_REG_CTL_LO: ctl_pay_r[31:0] <= wdata[31:0];
        `LDL_REG_CTL_HI: begin
          if (!ctl_busy_r) begin
            ctl_pay_r[35:32] <= wdata[`LDL_CTLHI_PAY_W-1:0];
            ctl_wen_r        <= wdata[`LDL_CTLHI_WEN];
          end
        end
        default: ;
      endcase
    end
  end

  // Control sequence: one byte per frame, advanced at frame start
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctl_busy_r <= 1'b0;
      ctl_idx_r  <= 3'h0;
      ctl_sent_r <= 1'b0;
    end else if (wr && addr == `LDL_REG_CTL_HI && !ctl_busy_r) begin
      ctl_busy_r <= 1'b1;
      ctl_idx_r  <= 3'h0;
      ctl_sent_r <= 1'b0;
    end else if (ctl_busy_r) begin
      if (frame_start && ctl_sent_r) begin
        ctl_sent_r <= 1'b0;
        if (ctl_idx_r == `LDL_CTL_LAST)
          ctl_busy_r <= 1'b0;
        else
          ctl_idx_r <= ctl_idx_r + 3'h1;
      end else if (fall && dir_s) begin
        ctl_sent_r <= 1'b1;
      end
    end
  end

  // Voice goes in exactly one slot, the other idles
  always_comb begin
    tx_frame.voice_pri = (vsel_r == LDL_VOICE_PRI) ? tx_voice_r
                                                   : `LDL_IDLE_BYTE;
    tx_frame.voice_sec = (vsel_r == LDL_VOICE_SEC) ? tx_voice_r
                                                   : `LDL_IDLE_BYTE;
    tx_frame.control   = ctl_byte_f(ctl_busy_r, ctl_idx_r, ctl_wen_r,
                                    ctl_pay_r);
    tx_frame.signaling = tx_sig_r;
  end

  // Transmit half: load during inbound half, shift out MSB first
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_sh_r    <= '1;
      out_data_r <= 1'b1;
    end else if (fall) begin
      if (dir_s) begin
        tx_sh_r <= tx_frame;
      end else begin
        out_data_r <= tx_sh_r[31];
        tx_sh_r    <= {tx_sh_r[30:0], 1'b1};
      end
    end
  end
  assign link.mod_out_data = out_data_r;
  // One wire: release the shared wire while the board talks
  assign link.mod_out_en = ~one_wire_r | ~dir_s;

  // Receive half: 32 bits on the wire chosen by the strap
  assign bit_in = one_wire_r ? outw_s : inw_s;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_sh_r   <= '0;
      rx_cnt_r  <= 5'h00;
      rx_word_r <= '1;
      frames_r  <= 8'h00;
    end else if (!dir_s) begin
      rx_cnt_r <= 5'h00;
    end else if (rise) begin
      rx_sh_r  <= {rx_sh_r[30:0], bit_in};
      rx_cnt_r <= rx_cnt_r + 5'h01;
      if (rx_cnt_r == 5'h1F) begin
        rx_word_r <= {rx_sh_r[30:0], bit_in};
        frames_r  <= frames_r + 8'h01;
      end
    end
  end

  // Identification byte: first byte time of outbound half
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lo_cnt_r <= 4'h0;
      in_sh_r  <= 8'h00;
    end else if (dir_s) begin
      lo_cnt_r <= 4'h0;
    end else if (rise && lo_cnt_r <= `LDL_ID_LAST) begin
      lo_cnt_r <= lo_cnt_r + 4'h1;
      in_sh_r  <= {in_sh_r[6:0], inw_s};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      id_armed_r <= 1'b0;
      id_valid_r <= 1'b0;
      id_r       <= 8'h00;
    end else if (!run_r) begin
      id_armed_r <= 1'b0;
      id_valid_r <= 1'b0;
    end else if (frame_start && !id_valid_r) begin
      id_armed_r <= 1'b1;
    end else if (id_armed_r && !dir_s && rise
                 && lo_cnt_r == `LDL_ID_LAST) begin
      id_r       <= {in_sh_r[6:0], inw_s};
      id_valid_r <= 1'b1;
      id_armed_r <= 1'b0;
    end
  end

  always_comb begin
    status_w = '0;
    status_w[`LDL_ST_ID_LSB +: 8] = id_r;
    status_w[`LDL_ST_ID_VALID]    = id_valid_r;
    status_w[`LDL_ST_ONE_WIRE]    = one_wire_r;
    status_w[`LDL_ST_PRESENT]     = ~pres_n_s;
    status_w[`LDL_ST_CTL_BUSY]    = ctl_busy_r;
    status_w[`LDL_ST_FRM_LSB +: 8] = frames_r;
    rxdata_w = '0;
    rxdata_w[`LDL_RX_VOICE_LSB +: 8] = (vsel_r == LDL_VOICE_PRI)
                                       ? rx_word_r[31:24]
                                       : rx_word_r[23:16];
    rxdata_w[`LDL_RX_CTL_LSB +: 8] = rx_word_r[15:8];
    rxdata_w[`LDL_RX_SIG_LSB +: 8] = rx_word_r[7:0];
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        `LDL_REG_CTRL: begin
          rdata <= '0;
          rdata[`LDL_CTRL_RUN]  <= run_r;
          rdata[`LDL_CTRL_VSEL] <= vsel_r;
        end
        `LDL_REG_TXDATA: begin
          rdata <= '0;
          rdata[`LDL_TX_VOICE_LSB +: 8] <= tx_voice_r;
          rdata[`LDL_TX_SIG_LSB +: 8]   <= tx_sig_r;
        end
        `LDL_REG_CTL_LO: rdata <= ctl_pay_r[31:0];
        `LDL_REG_CTL_HI: begin
          rdata <= '0;
          rdata[`LDL_CTLHI_PAY_W-1:0] <= ctl_pay_r[35:32];
          rdata[`LDL_CTLHI_WEN]       <= ctl_wen_r;
        end
        `LDL_REG_STATUS: rdata <= status_w;
        `LDL_REG_RXDATA: rdata <= rxdata_w;
        default:         rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

// >>> verilog/ldl_board_end.sv
// Line interface board end: timing master of the line datalink
`timescale 1ns/1ns
`include "ldl_defs.svh"
module ldl_board_end
  import ldl_pkg::*;
#(
  parameter int        HALF     = `LDL_HALF_CYC,
  parameter ldl_byte_t ID_CODE  = 8'h5A, // Arbitrary value
  parameter logic      ONE_WIRE = 1'b1
) (
  input  wire logic      ref_clk,
  input  wire logic      nrst,
  ldl_link_if.board_mp   link,
  input  wire ldl_word_t tx_word,
  output ldl_word_t      rx_word,
  output logic           frame_done,
  output logic           running,
  output logic           module_seen
);
  logic [2:0] pin_s;
  logic       outw_s, run_s, mpres_n_s;
  logic [4:0] half_cnt_r;
  logic       clk_r, dir_r, tick, fall_b, rise_b;
  logic [5:0] idx_r, nidx;
  ldl_word_t  frame_r, rx_sh_r;
  logic       out_data_r, out_en_r, in_data_r, in_en_r;

  ldl_sync #(.W(3)) ldl_sync_inst (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     ({link.out_wire, link.interface_board_reset_n,
               link.module_present_n}),
    .dout    (pin_s)
  );
  assign {outw_s, run_s, mpres_n_s} = pin_s;
  assign running     = run_s;
  assign module_seen = ~mpres_n_s;

  // Bit clock divided down from the reference clock
  assign tick   = half_cnt_r == 5'(HALF - 1);
  assign fall_b = tick & clk_r;
  assign rise_b = tick & ~clk_r;
  assign nidx   = idx_r + 6'h01;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      half_cnt_r <= 5'h00;
      clk_r      <= 1'b1;
      idx_r      <= 6'h3F;
      dir_r      <= 1'b0;
    end else begin
      half_cnt_r <= tick ? 5'h00 : half_cnt_r + 5'h01;
      if (tick)
        clk_r <= ~clk_r;
      if (fall_b) begin
        idx_r <= nidx;
        dir_r <= ~nidx[5];
      end
    end
  end
  assign link.bit_clk             = clk_r;
  assign link.link_direction      = dir_r;
  assign link.wire_mode_n         = ~ONE_WIRE;
  assign link.interface_present_n = 1'b0;

  // Drive data on falling edges: frame bits, then ID in outbound half
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      frame_r    <= '1;
      out_data_r <= 1'b1;
      out_en_r   <= 1'b0;
      in_data_r  <= 1'b1;
      in_en_r    <= 1'b0;
    end else if (!run_s) begin
      // Held in reset: let go of both wires at once
      out_en_r <= 1'b0;
      in_en_r  <= 1'b0;
    end else if (fall_b) begin
      if (nidx == 6'h00)
        frame_r <= tx_word;
      out_data_r <= (nidx == 6'h00) ? tx_word[31] : frame_r[~nidx[4:0]];
      out_en_r   <= ONE_WIRE & ~nidx[5] & run_s;
      if (nidx[5:3] == 3'h4) begin
        in_data_r <= ID_CODE[~nidx[2:0]];
        in_en_r   <= run_s;
      end else begin
        in_data_r <= (nidx == 6'h00) ? tx_word[31]
                                     : frame_r[~nidx[4:0]];
        in_en_r   <= ~ONE_WIRE & ~nidx[5] & run_s;
      end
    end
  end
  assign link.brd_out_data = out_data_r;
  assign link.brd_out_en   = out_en_r;
  assign link.brd_in_data  = in_data_r;
  assign link.brd_in_en    = in_en_r;

  // Sample module data on rising edges of the outbound half
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_sh_r    <= '0;
      rx_word    <= '1;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (rise_b && idx_r[5]) begin
        rx_sh_r <= {rx_sh_r[30:0], outw_s};
        if (idx_r == 6'h3F && run_s) begin
          rx_word    <= {rx_sh_r[30:0], outw_s};
          frame_done <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> test/ldl_link_sva.sv
// Concurrent checks on the cable between module end and board end
`timescale 1ns/1ns
module ldl_link_sva #(
  parameter int HALF = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic bit_clk,
  input wire logic link_direction,
  input wire logic mod_out_en,
  input wire logic brd_out_en,
  input wire logic brd_in_en,
  input wire logic identification_line,
  input wire logic interface_board_reset_n,
  input wire logic module_present_n,
  input wire logic wire_mode_n
);
  logic       bc_q;
  logic       dir_q;
  logic       seen_d;
  logic       seen_c;
  logic [6:0] rises;
  logic [7:0] lvl;
  logic       chg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  assign chg = link_direction != dir_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bc_q  <= 1'b1;
      dir_q <= 1'b0;
    end else begin
      bc_q  <= bit_clk;
      dir_q <= link_direction;
    end
  end

  // Bit clock rises seen since the last direction change
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rises  <= 7'h00;
      seen_d <= 1'b0;
    end else if (chg) begin
      rises  <= 7'h00;
      seen_d <= interface_board_reset_n;
    end else if (bit_clk && !bc_q) begin
      rises <= rises + 7'h01;
    end
  end

  // Cycles the bit clock has held its present level
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lvl    <= 8'h00;
      seen_c <= 1'b0;
    end else if (bit_clk != bc_q) begin
      lvl    <= 8'h01;
      seen_c <= 1'b1;
    end else if (lvl != 8'hFF) begin
      lvl <= lvl + 8'h01;
    end
  end

  a_present_low: assert property (module_present_n == 1'b0)
    else $error("module present output not asserted");
  a_reset_run: assert property (disable iff (1'b0)
    !nrst |=> !interface_board_reset_n)
    else $error("board reset not driven during module reset");
  a_dir_32_bits: assert property (seen_d && chg |-> rises == 7'h20)
    else $error("direction half not 32 bits long");
  a_clk_half_len: assert property (seen_c && (bit_clk != bc_q) |->
    int'(lvl) >= HALF && int'(lvl) <= HALF + 1)
    else $error("bit clock half period wrong");
  a_dir_on_fall: assert property ($changed(link_direction) |->
    $fell(bit_clk))
    else $error("direction changed away from a clock fall");
  a_out_half: assert property ((!link_direction)[*6] |-> mod_out_en)
    else $error("module not driving outbound wire in its half");
  a_in_quiet: assert property ((!wire_mode_n && link_direction)[*6]
    |-> !mod_out_en)
    else $error("module drives shared wire in inbound half");
  a_id_dir: assert property (brd_in_en |-> !link_direction)
    else $error("inbound wire driven with direction high");
  a_board_quiet: assert property ((!interface_board_reset_n)[*4]
    |-> !brd_in_en && !brd_out_en)
    else $error("board drives wires while held in reset");

  c_frame: cover property (seen_d && chg && !link_direction);
  c_id_bit: cover property (brd_in_en && !identification_line);
  c_run: cover property ($rose(interface_board_reset_n));
endmodule

// >>> test/ldl_slave_port_tb.sv
// Testbench: module end and board end joined over the link interface
`timescale 1ns/1ns
module line_datalink_slave_port_tb import ldl_pkg::*;;
  localparam int HALF_SIM = 8;
  logic        ref_clk;
  logic        nrst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  ldl_word_t   tx_word;
  ldl_word_t   rx_word;
  logic        frame_done;
  logic        running;
  logic        module_seen;
  logic [31:0] rv;
  int          failures;
  int          compares;

  ldl_link_if ldl_link_if_inst ();
  ldl_module_end ldl_module_end_inst (
    .ref_clk(ref_clk), .nrst(nrst), .link(ldl_link_if_inst.module_mp),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ldl_board_end #(.HALF(HALF_SIM)) ldl_board_end_inst (
    .ref_clk(ref_clk), .nrst(nrst), .link(ldl_link_if_inst.board_mp),
    .tx_word(tx_word), .rx_word(rx_word), .frame_done(frame_done),
    .running(running), .module_seen(module_seen));
  ldl_link_sva #(.HALF(HALF_SIM)) ldl_link_sva_inst (
    .ref_clk(ref_clk), .nrst(nrst),
    .bit_clk(ldl_link_if_inst.bit_clk),
    .link_direction(ldl_link_if_inst.link_direction),
    .mod_out_en(ldl_link_if_inst.mod_out_en),
    .brd_out_en(ldl_link_if_inst.brd_out_en),
    .brd_in_en(ldl_link_if_inst.brd_in_en),
    .identification_line(ldl_link_if_inst.identification_line),
    .interface_board_reset_n(ldl_link_if_inst.interface_board_reset_n),
    .module_present_n(ldl_link_if_inst.module_present_n),
    .wire_mode_n(ldl_link_if_inst.wire_mode_n));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Waits for n board frame ends, each bounded
  task automatic wait_frames(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge ref_clk);
        #1;
        k++;
      end while (frame_done !== 1'b1 && k < 1200);
      if (k >= 1200) failures++;
    end
  endtask

  task automatic t_reset_state;
    rd_reg(8'h00, rv);
    check("ctrl", rv, 32'h00000000);
    rd_reg(8'h04, rv);
    check("txdata", rv, 32'h0000FFFF);
    rd_reg(8'h20, rv);
    check("unmapped", rv, 32'h00000000);
    rd_reg(8'h10, rv);
    check("strap", {30'h0, rv[10:9]}, 32'h00000003);
    check("running", {31'h0, running}, 32'h00000000);
    check("module seen", {31'h0, module_seen}, 32'h00000001);
  endtask

  task automatic t_run_id;
    logic [7:0] f0;
    wr_reg(8'h00, 32'h00000001);
    wait_frames(2);
    check("running", {31'h0, running}, 32'h00000001);
    rd_reg(8'h10, rv);
    check("id", {23'h0, rv[8:0]}, 32'h0000015A);
    f0 = rv[23:16];
    wait_frames(4);
    rd_reg(8'h10, rv);
    check("frames", {24'h0, rv[23:16] - f0}, 32'h00000004);
  endtask

  task automatic t_voice;
    logic [31:0] exp;
    @(posedge ref_clk);
    tx_word <= 32'hA1B2C3D4;
    wr_reg(8'h04, 32'h0000963C);
    for (int s = 0; s < 2; s++) begin
      wr_reg(8'h00, {30'h0, s[0], 1'b1});
      wait_frames(3);
      exp = s[0] ? 32'hFF3CFF96 : 32'h3CFFFF96;
      check("board rx", rx_word, exp);
      rd_reg(8'h14, rv);
      exp = s[0] ? 32'h00D4C3B2 : 32'h00D4C3A1;
      check("module rx", {8'h0, rv[23:0]}, exp);
    end
  endtask

  task automatic t_ctl;
    logic [35:0] pay;
    logic [7:0]  b;
    int          k;
    pay = 36'h9ABCDE123;
    wr_reg(8'h08, pay[31:0]);
    wr_reg(8'h0C, {23'h0, 1'b1, 4'h0, pay[35:32]});
    // Second start while busy must leave the sequence untouched
    wr_reg(8'h0C, 32'h0000000F);
    rd_reg(8'h10, rv);
    check("busy", {31'h0, rv[11]}, 32'h00000001);
    k = 0;
    wait_frames(1);
    while (rx_word[15:8] === 8'hFF && k < 4) begin
      wait_frames(1);
      k++;
    end
    for (int i = 0; i < 6; i++) begin
      b = {i != 0, 1'b0, pay[35 - 6 * i -: 6]};
      check("ctl byte", {24'h0, rx_word[15:8]}, {24'h0, b});
      wait_frames(1);
    end
    check("ctl idle", {24'h0, rx_word[15:8]}, 32'h000000FF);
    rd_reg(8'h10, rv);
    check("busy end", {31'h0, rv[11]}, 32'h00000000);
  endtask

  task automatic t_stop;
    wr_reg(8'h00, 32'h00000000);
    repeat (10) @(posedge ref_clk);
    #1;
    check("stopped", {31'h0, running}, 32'h00000000);
    rd_reg(8'h10, rv);
    check("id valid", {31'h0, rv[8]}, 32'h00000000);
    wr_reg(8'h00, 32'h00000001);
    wait_frames(1);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check("reset run", {31'h0, running}, 32'h00000000);
    rd_reg(8'h00, rv);
    check("ctrl reset", rv, 32'h00000000);
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end

  initial begin
    nrst     = 1'b0;
    addr     = 8'h00;
    wdata    = 32'h00000000;
    wr       = 1'b0;
    rd       = 1'b0;
    tx_word  = 32'hFFFFFFFF;
    failures = 0;
    compares = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset_state();
    t_run_id();
    t_voice();
    t_ctl();
    t_stop();
    wrap_up();
  end
endmodule
